//--- rmlc_regs.vh
`ifndef RMLC_REGS_VH
`define RMLC_REGS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define RMLC_CLK_NS 10
`define RMLC_MS_NS 1000000
`define RMLC_IDLE_BITS 5'h10
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RMLC_OFS_CTRL 5'h00
`define RMLC_OFS_BLOCK 5'h04
`define RMLC_OFS_PRE 5'h08
`define RMLC_OFS_TOL 5'h0c
`define RMLC_OFS_ACKW 5'h10
`define RMLC_OFS_TXON 5'h14
`define RMLC_OFS_STAT 5'h18
// ----------------------------------------
// Control and status fields and reset values
// ----------------------------------------
`define RMLC_CTRL_EN 0
`define RMLC_CTRL_MAN 1
`define RMLC_CTRL_PACE_LO 2
`define RMLC_CTRL_TEST 4
`define RMLC_STAT_OVF 13
`define RMLC_PACE_NONE 2'h0
`define RMLC_PACE_SW 2'h1
`define RMLC_PACE_HW 2'h2
`define RMLC_RST_CTRL 5'h05
`define RMLC_RST_BLOCK 9'h080
`define RMLC_RST_PRE 8'h20
`define RMLC_RST_TOL 2'h1
`define RMLC_RST_ACKW 16'h03e8
`define RMLC_RST_TXON 8'h14
// ----------------------------------------
// Frame patterns and characters
// ----------------------------------------
`define RMLC_SDET_PAT 6'h2b
`define RMLC_START_PAT 16'hb433
`define RMLC_END_PAT 16'h7e5a
`define RMLC_XON 8'h11
`define RMLC_XOFF 8'h13
`define RMLC_MSG "TEST 0123456789"
`define RMLC_MSG_LEN 9'h00f
`endif

//--- rmlc_link_ctrl.v
// Summary of operation
// - Software pacing: send XOFF before host receive buffer overflows.
// - Software pacing: send XON once the buffer has room again.
// - Hardware pacing: drop CTS before overflow, raise it when room returns.
// - No pacing: keep accepting host data; overflowing bytes are lost.
// - Auto mode: buffer host data during key-up, send after preparation.
// - Push-to-talk mode: host data alone never starts a transmission.
// - Push-to-talk mode: RTS disables receive, keys transmitter, data follows.
// - Correct block is acknowledged; sender then goes on to next block (auto mode only here).
// - Bad block gets no acknowledge; sender continues after wait period (push-to-talk mode here neither acknowledges nor waits).
// - Host pacing starts once one block size of data is buffered.
// - Frame order: preamble, start-detect bits, start pattern, payload, end.
// - Preamble length in bits is configurable.
// - Start-detect field is exactly 6 bits.
// - Start pattern accepted within configurable error tolerance up to 3 bits.
// - Reception ends after 16 bit periods without detected data.
// - Test mode sends a fixed internal ASCII message without host data.
// - Hardware pacing and push-to-talk mode both use the RTS line (here hardware pacing drives only CTS and ignores RTS).
// - Push-to-talk mode forces pacing off; auto allows any pacing.
// - Acknowledge wait is configurable, 1000 ms by default.
// - Block size is configurable, 128 bytes by default.
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "rmlc_regs.vh"
module rmlc_link_ctrl #(
  parameter [31:0] MS_CYCLES = `RMLC_MS_NS / `RMLC_CLK_NS
) (
  input wire clk, // System clock
  input wire srst, // Synchronous reset
  input wire [4:0] avs_address, // Byte address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  output reg [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Stall
  input wire [7:0] host_rx_data, // Byte from host UART
  input wire host_rx_valid, // Host byte strobe
  output reg [7:0] host_tx_data, // Byte to host UART
  output reg host_tx_valid, // Byte to host valid
  input wire host_tx_ready, // Host UART takes byte
  input wire rts_pin, // RTS from host, async
  output reg cts_pin, // CTS to host
  output reg push_to_talk_line, // Transmitter key
  output reg rx_enable, // Receive path enable
  input wire tx_bit_tick, // Modulator wants a bit
  output reg tx_bit, // Bit to modulator
  input wire rx_bit_tick, // Demodulator bit strobe
  input wire rx_bit, // Bit from demodulator
  input wire rx_data_detect // Demodulator sees data
);
  localparam S_IDLE = 3'h0, S_KEY = 3'h1, S_PRE = 3'h2, S_SDET = 3'h3;
  localparam S_START = 3'h4, S_DATA = 3'h5, S_END = 3'h6, S_WACK = 3'h7;
  localparam [8*15-1:0] MSG = `RMLC_MSG;
  localparam [5:0] SDET_BITS = `RMLC_SDET_PAT;
  localparam [15:0] START_BITS = `RMLC_START_PAT;
  localparam [15:0] END_BITS = `RMLC_END_PAT;

  function [4:0] ones16;
    input [15:0] v;
    integer i;
    begin
      ones16 = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        ones16 = ones16 + {4'h0, v[i]};
      end
    end
  endfunction

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  reg ack_q;
  reg [4:0] ctrl_q;
  reg [8:0] blk_q;
  reg [7:0] pre_q;
  reg [1:0] tol_q;
  reg [15:0] ackw_q;
  reg [7:0] txon_q;
  reg ovf_q;
  reg [8:0] fill_q;
  reg [2:0] st_q;
  reg rx_in_q;
  reg xoff_q;
  wire wr_go = avs_write & ack_q;
  wire ovf_set;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  wire manual = ctrl_q[`RMLC_CTRL_MAN];
  wire test = ctrl_q[`RMLC_CTRL_TEST];
  wire [1:0] pace = manual ? `RMLC_PACE_NONE : ctrl_q[`RMLC_CTRL_PACE_LO+1:`RMLC_CTRL_PACE_LO];

  // One wait cycle per access; read data captured as the stall drops
  always @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0;
      ctrl_q <= `RMLC_RST_CTRL;
      blk_q <= `RMLC_RST_BLOCK;
      pre_q <= `RMLC_RST_PRE;
      tol_q <= `RMLC_RST_TOL;
      ackw_q <= `RMLC_RST_ACKW;
      txon_q <= `RMLC_RST_TXON;
      ovf_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read & ~ack_q) begin
        case (avs_address)
          `RMLC_OFS_CTRL: avs_readdata <= {27'h0, ctrl_q};
          `RMLC_OFS_BLOCK: avs_readdata <= {23'h0, blk_q};
          `RMLC_OFS_PRE: avs_readdata <= {24'h0, pre_q};
          `RMLC_OFS_TOL: avs_readdata <= {30'h0, tol_q};
          `RMLC_OFS_ACKW: avs_readdata <= {16'h0, ackw_q};
          `RMLC_OFS_TXON: avs_readdata <= {24'h0, txon_q};
          `RMLC_OFS_STAT: avs_readdata <= {17'h0, st_q == S_WACK, ovf_q, cts_pin, xoff_q,
                                           rx_in_q, push_to_talk_line, fill_q};
          default: avs_readdata <= 32'h0;
        endcase
      end
      if (wr_go) begin
        case (avs_address)
          `RMLC_OFS_CTRL: ctrl_q <= avs_writedata[4:0];
          `RMLC_OFS_BLOCK: blk_q <= avs_writedata[8:0];
          `RMLC_OFS_PRE: pre_q <= avs_writedata[7:0];
          `RMLC_OFS_TOL: tol_q <= avs_writedata[1:0];
          `RMLC_OFS_ACKW: ackw_q <= avs_writedata[15:0];
          `RMLC_OFS_TXON: txon_q <= avs_writedata[7:0];
          default: ;
        endcase
      end
      // Overflow flag: a new loss beats a write-one clear
      if (ovf_set)
        ovf_q <= 1'b1;
      else if (wr_go && avs_address == `RMLC_OFS_STAT && avs_writedata[`RMLC_STAT_OVF])
        ovf_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // RTS synchroniser and millisecond tick
  // ----------------------------------------
  reg [2:0] rts_sh_q;
  reg rts_q;
  reg [31:0] ms_cnt_q;
  wire ms_tick = (ms_cnt_q == MS_CYCLES - 32'h1);
  // Third and second stage must agree before RTS is believed
  always @(posedge clk) begin
    if (srst) begin
      rts_sh_q <= 3'h0;
      rts_q <= 1'b0;
      ms_cnt_q <= 32'h0;
    end else begin
      rts_sh_q <= {rts_sh_q[1:0], rts_pin};
      if (rts_sh_q[1] == rts_sh_q[2])
        rts_q <= rts_sh_q[2];
      ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Host receive buffer
  // ----------------------------------------
  reg [7:0] mem_q [0:255];
  reg [7:0] wp_q;
  reg [7:0] rp_q;
  wire pop;
  wire empty = (fill_q == 9'h000);
  wire full = fill_q[8];
  wire push = host_rx_valid & ~full;
  assign ovf_set = host_rx_valid & full;
  // Data keeps flowing into the buffer whatever the pacing scheme
  always @(posedge clk) begin
    if (srst) begin
      wp_q <= 8'h00;
      rp_q <= 8'h00;
      fill_q <= 9'h000;
    end else begin
      if (push) begin
        mem_q[wp_q] <= host_rx_data;
        wp_q <= wp_q + 8'h01;
      end
      if (pop)
        rp_q <= rp_q + 8'h01;
      fill_q <= fill_q + {8'h00, push} - {8'h00, pop};
    end
  end

  // ----------------------------------------
  // Host pacing and host-bound bytes
  // ----------------------------------------
  // Threshold at one block; hysteresis to half a block avoids chatter
  wire hi = (fill_q >= blk_q) | full;
  wire lo = fill_q <= {1'b0, blk_q[8:1]};
  reg flow_pend_q;
  reg [7:0] flow_ch_q;
  reg hold_v_q;
  reg [7:0] hold_q;
  wire rx_byte_v;
  wire [7:0] rx_byte;
  always @(posedge clk) begin
    if (srst) begin
      xoff_q <= 1'b0;
      cts_pin <= 1'b1;
      flow_pend_q <= 1'b0;
      flow_ch_q <= 8'h00;
      hold_v_q <= 1'b0;
      hold_q <= 8'h00;
      host_tx_valid <= 1'b0;
      host_tx_data <= 8'h00;
    end else begin
      if (pace == `RMLC_PACE_HW) begin
        if (hi)
          cts_pin <= 1'b0;
        else if (lo)
          cts_pin <= 1'b1;
      end else
        cts_pin <= 1'b1;
      if (pace == `RMLC_PACE_SW && hi && !xoff_q) begin
        xoff_q <= 1'b1;
        flow_pend_q <= 1'b1;
        flow_ch_q <= `RMLC_XOFF;
      end else if (xoff_q && (lo || pace != `RMLC_PACE_SW)) begin
        xoff_q <= 1'b0;
        flow_pend_q <= 1'b1;
        flow_ch_q <= `RMLC_XON;
      end else if (flow_pend_q && (!host_tx_valid || host_tx_ready))
        flow_pend_q <= 1'b0;
      // Single holding byte: radio data arriving faster than the host drains is lost
      if (rx_byte_v) begin
        hold_v_q <= 1'b1;
        hold_q <= rx_byte;
      end else if (!flow_pend_q && hold_v_q && (!host_tx_valid || host_tx_ready))
        hold_v_q <= 1'b0;
      if (!host_tx_valid || host_tx_ready) begin
        host_tx_valid <= flow_pend_q | hold_v_q;
        host_tx_data <= flow_pend_q ? flow_ch_q : hold_q;
      end
    end
  end

  // ----------------------------------------
  // Radio receiver
  // ----------------------------------------
  reg [15:0] win_q;
  reg [2:0] rbc_q;
  reg [8:0] rn_q;
  reg [4:0] idle_q;
  reg ack_seen_q;
  reg ack_pend_q;
  wire ack_take;
  wire [15:0] win_n = {win_q[14:0], rx_bit};
  wire rtick = rx_bit_tick & rx_enable;
  wire byte_end = rtick & rx_in_q & (rbc_q == 3'h7);
  wire end_hit = byte_end & (win_n == `RMLC_END_PAT);
  assign rx_byte_v = byte_end & ~end_hit & (rn_q != 9'h000);
  assign rx_byte = win_n[15:8];
  always @(posedge clk) begin
    if (srst) begin
      win_q <= 16'h0;
      rx_in_q <= 1'b0;
      rbc_q <= 3'h0;
      rn_q <= 9'h000;
      idle_q <= 5'h00;
      ack_seen_q <= 1'b0;
      ack_pend_q <= 1'b0;
    end else begin
      ack_seen_q <= end_hit & (rn_q == 9'h001);
      if (end_hit && rn_q > 9'h001 && !manual)
        ack_pend_q <= 1'b1;
      else if (ack_take)
        ack_pend_q <= 1'b0;
      if (!rx_enable) begin
        rx_in_q <= 1'b0;
        idle_q <= 5'h00;
      end else if (rtick) begin
        win_q <= win_n;
        idle_q <= rx_data_detect ? 5'h00 : idle_q + 5'h01;
        if (!rx_in_q) begin
          if (ones16(win_n ^ `RMLC_START_PAT) <= {3'h0, tol_q}) begin
            rx_in_q <= 1'b1;
            rbc_q <= 3'h0;
            rn_q <= 9'h000;
          end
        end else if (!rx_data_detect && idle_q == `RMLC_IDLE_BITS - 5'h01)
          rx_in_q <= 1'b0;
        else begin
          rbc_q <= rbc_q + 3'h1;
          if (end_hit)
            rx_in_q <= 1'b0;
          else if (byte_end)
            rn_q <= rn_q + 9'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // Radio transmitter
  // ----------------------------------------
  reg is_ack_q;
  reg [8:0] fcnt_q;
  reg [8:0] nb_q;
  reg [7:0] sr_q;
  reg [3:0] mi_q;
  reg [15:0] tmr_q;
  reg [2:0] st_d;
  wire avail = test | ~empty;
  wire [8:0] lim = test ? `RMLC_MSG_LEN : blk_q;
  wire go = ctrl_q[`RMLC_CTRL_EN] & (manual ? rts_q : avail);
  wire more = avail & (nb_q + 9'h001 < lim) & (~manual | rts_q);
  wire [7:0] nxt = test ? MSG[8*(14-mi_q) +: 8] : mem_q[rp_q];
  wire ttick = tx_bit_tick & (st_q >= S_PRE) & (st_q <= S_END);
  wire load = (st_q == S_START && ttick && fcnt_q == 9'h00f && !is_ack_q && avail) |
              (st_q == S_DATA && ttick && fcnt_q[2:0] == 3'h7 && more);
  assign pop = load & ~test;
  assign ack_take = (st_q == S_IDLE) & ack_pend_q & ~manual;

  // Next state of the frame sequencer
  always @* begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (ack_take || go) st_d = S_KEY;
      S_KEY: if (tmr_q >= {8'h00, txon_q}) st_d = S_PRE;
      S_PRE: if (ttick && fcnt_q + 9'h001 >= {1'b0, pre_q}) st_d = S_SDET;
      S_SDET: if (ttick && fcnt_q == 9'h005) st_d = S_START;
      S_START: if (ttick && fcnt_q == 9'h00f) st_d = load ? S_DATA : S_END;
      S_DATA: if (ttick && fcnt_q[2:0] == 3'h7 && !more) st_d = S_END;
      S_END: begin
        if (ttick && fcnt_q == 9'h00f)
          st_d = (is_ack_q || manual) ? S_IDLE : S_WACK;
      end
      S_WACK: if (ack_seen_q || tmr_q >= ackw_q) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    // Dropping RTS in push-to-talk mode ends the transmission at once
    if (manual && !rts_q && st_q != S_IDLE)
      st_d = S_IDLE;
  end

  // Serialiser: one frame bit per modulator tick, MSB first
  always @(posedge clk) begin
    if (srst) begin
      st_q <= S_IDLE;
      is_ack_q <= 1'b0;
      fcnt_q <= 9'h000;
      nb_q <= 9'h000;
      sr_q <= 8'h00;
      mi_q <= 4'h0;
      tmr_q <= 16'h0;
      tx_bit <= 1'b0;
      push_to_talk_line <= 1'b0;
      rx_enable <= 1'b1;
    end else begin
      st_q <= st_d;
      if (st_q == S_IDLE)
        is_ack_q <= ack_take;
      // Keyed from key-up to end of frame; off while awaiting the acknowledge
      push_to_talk_line <= (st_d != S_IDLE) && (st_d != S_WACK);
      rx_enable <= ~((st_d != S_IDLE) && (st_d != S_WACK)) & ~(manual & rts_q);
      if (st_d != st_q)
        tmr_q <= 16'h0;
      else if (ms_tick && tmr_q != 16'hffff)
        tmr_q <= tmr_q + 16'h1;
      if (st_d != st_q)
        fcnt_q <= 9'h000;
      else if (ttick)
        fcnt_q <= fcnt_q + 9'h001;
      if (st_q == S_START)
        nb_q <= 9'h000;
      else if (load)
        nb_q <= nb_q + 9'h001;
      if (load) begin
        sr_q <= nxt;
        if (test)
          mi_q <= (mi_q == 4'he) ? 4'h0 : mi_q + 4'h1;
      end else if (st_q == S_DATA && ttick)
        sr_q <= {sr_q[6:0], 1'b0};
      if (ttick) begin
        case (st_q)
          S_PRE: tx_bit <= ~fcnt_q[0];
          S_SDET: tx_bit <= SDET_BITS[3'h5 - fcnt_q[2:0]];
          S_START: tx_bit <= START_BITS[4'hf - fcnt_q[3:0]];
          S_DATA: tx_bit <= sr_q[7];
          S_END: tx_bit <= END_BITS[4'hf - fcnt_q[3:0]];
          default: tx_bit <= 1'b0;
        endcase
      end
    end
  end
endmodule // rmlc_link_ctrl

//--- rmlc_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module rmlc_checker (
  input wire clk, // Clock
  input wire srst, // Reset
  input wire [4:0] avs_address, // Address
  input wire avs_read, // Read
  input wire avs_write, // Write
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Stall
  input wire host_tx_valid, // Byte to host
  input wire host_tx_ready, // Host takes
  input wire cts_pin, // CTS
  input wire push_to_talk_line, // Key
  input wire rx_enable, // Receive on
  input wire tx_bit_tick, // Bit request
  input wire tx_bit // Bit out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire req = avs_read | avs_write;

  // Every request sees exactly one wait cycle
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait on new request");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("second wait cycle");
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && (avs_address > 5'h18 || avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // Idle levels right after reset
  a_reset_vals: assert property ($fell(srst) |-> cts_pin && rx_enable
    && !push_to_talk_line && !host_tx_valid && !tx_bit)
    else $error("bad level after reset");
  // A stalled byte to the host, pacing characters too, stays offered
  a_tx_hold: assert property (host_tx_valid && !host_tx_ready |=> host_tx_valid)
    else $error("byte to host withdrawn");
  // Frame bits move only on the modulator's request and while keyed
  a_bit_on_tick: assert property ($changed(tx_bit) && push_to_talk_line |-> $past(tx_bit_tick))
    else $error("bit changed without tick");
  a_bit_keyed: assert property ($rose(tx_bit) |-> push_to_talk_line)
    else $error("bit sent while unkeyed");
endmodule // rmlc_checker

bind rmlc_link_ctrl rmlc_checker rmlc_checker_i (.clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .host_tx_valid, .host_tx_ready, .cts_pin,
  .push_to_talk_line, .rx_enable, .tx_bit_tick, .tx_bit);

//--- rmlc_host_model.sv
`timescale 1ns/1ps
`include "rmlc_regs.vh"
// ----------------------------------------
// Host terminal model
// ----------------------------------------
module rmlc_host_model (
  input wire clk, // Clock
  input wire srst, // Reset
  input wire stall, // Hold off device bytes
  input wire want_send, // Host has data
  input wire [7:0] host_tx_data, // Byte from device
  input wire host_tx_valid, // Byte valid
  output wire host_tx_ready, // Byte taken
  output reg rts_pin, // Request to send
  output reg paused // Halted by pacing
);
  assign host_tx_ready = !stall;
  // Obey pacing characters; a stalled byte is not yet seen
  always @(posedge clk) begin
    if (srst) begin
      paused <= 1'b0;
      rts_pin <= 1'b0;
    end else begin
      rts_pin <= want_send;
      if (host_tx_valid && !stall && host_tx_data == `RMLC_XOFF)
        paused <= 1'b1;
      if (host_tx_valid && !stall && host_tx_data == `RMLC_XON)
        paused <= 1'b0;
    end
  end
endmodule // rmlc_host_model

//--- rmlc_link_ctrl_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link controller bench
// ----------------------------------------
module rmlc_link_ctrl_test;
  localparam int MS = 10;
  localparam logic [63:0] ACK = {16'hb432, 16'h7e5a, 32'h0};
  logic clk = 0;
  logic srst = 1;
  logic [4:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [7:0] host_rx_data = 0;
  logic host_rx_valid = 0;
  logic tx_bit_tick = 0;
  logic rx_bit_tick = 0;
  logic rx_bit = 0;
  logic rx_data_detect = 0;
  logic stall = 0;
  logic want_send = 0;
  wire [31:0] avs_readdata;
  wire [7:0] host_tx_data;
  wire avs_waitrequest, host_tx_valid, host_tx_ready, rts_pin, cts_pin;
  wire push_to_talk_line, rx_enable, tx_bit, paused;
  logic [31:0] q;
  logic [63:0] v;
  logic [7:0] pl [0:15];
  logic [31:0] rv [0:6] = '{32'h5, 32'h80, 32'h20, 32'h1, 32'h3e8, 32'h14, 32'h0};
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;

  rmlc_link_ctrl #(.MS_CYCLES(32'd10)) rmlc_link_ctrl_i (.clk, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .host_rx_data, .host_rx_valid, .host_tx_data, .host_tx_valid, .host_tx_ready,
    .rts_pin, .cts_pin, .push_to_talk_line, .rx_enable, .tx_bit_tick, .tx_bit,
    .rx_bit_tick, .rx_bit, .rx_data_detect);
  rmlc_host_model rmlc_host_model_i (.clk, .srst, .stall, .want_send, .host_tx_data,
    .host_tx_valid, .host_tx_ready, .rts_pin, .paused);

  initial forever #5 clk = ~clk;

  // Cut a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  // One bus cycle; the answer edge is the only one that counts
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      host_rx_data <= 8'h41 + 8'(i);
      host_rx_valid <= 1'b1;
      @(posedge clk);
    end
    host_rx_valid <= 1'b0;
    @(posedge clk);
  endtask

  // Pull n bits from the modulator side, newest in the low bit
  task automatic bits(input int n);
    v = 64'h0;
    repeat (n) begin
      tx_bit_tick <= 1'b1;
      @(posedge clk);
      tx_bit_tick <= 1'b0;
      repeat (2) @(posedge clk);
      v = {v[62:0], tx_bit};
    end
  endtask

  task automatic frame(input int pre, input int nb, input logic tail);
    while (!push_to_talk_line) @(posedge clk);
    repeat (20 * MS + 5) @(posedge clk);
    bits(pre);
    chk(v[31:0], 32'haaaaaaaa >> (32 - pre));
    bits(6);
    chk(v[31:0], 32'h2b);
    bits(16);
    chk(v[31:0], 32'hb433);
    for (int i = 0; i < nb; i++) begin
      bits(8);
      chk(v[31:0], {24'h0, pl[i]});
    end
    if (tail) begin
      bits(16);
      chk(v[31:0], 32'h7e5a);
    end
  endtask

  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, i == 6 ? 5'h1c : 5'(i * 4), 32'h0);
      chk(q, rv[i]);
    end
  endtask

  task automatic t_sw();
    bus(1'b1, 5'h04, 32'h8);
    bus(1'b1, 5'h10, 32'h3);
    bus(1'b1, 5'h08, 32'h8);
    stall <= 1'b1;
    send(8);
    repeat (3) @(posedge clk);
    chk({host_tx_valid, host_tx_data}, 9'h113);
    bus(1'b0, 5'h18, 32'h0);
    chk(q & 32'h3dff, 32'h1808);
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    chk(paused, 1'b1);
    frame(8, 8, 1'b1);
    chk(paused, 1'b0);
    bus(1'b0, 5'h18, 32'h0);
    chk(q[14], 1'b1);
    repeat (40) @(posedge clk);
    bus(1'b0, 5'h18, 32'h0);
    chk(q[14], 1'b0);
  endtask

  task automatic t_hw();
    bus(1'b1, 5'h00, 32'h9);
    bus(1'b1, 5'h10, 32'h32);
    want_send <= 1'b1;
    repeat (5) @(posedge clk);
    send(8);
    repeat (3) @(posedge clk);
    chk(cts_pin, 1'b0);
    frame(8, 8, 1'b1);
    chk(cts_pin, 1'b1);
    rx_data_detect <= 1'b1;
    for (int i = 63; i >= 0; i--) begin
      rx_bit <= ACK[i];
      rx_bit_tick <= 1'b1;
      @(posedge clk);
      rx_bit_tick <= 1'b0;
      @(posedge clk);
    end
    rx_data_detect <= 1'b0;
    want_send <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'b0, 5'h18, 32'h0);
    chk(q[14], 1'b0);
  endtask

  task automatic t_manual();
    do_reset();
    bus(1'b1, 5'h00, 32'h7);
    bus(1'b1, 5'h04, 32'h8);
    send(8);
    repeat (250) @(posedge clk);
    chk(push_to_talk_line, 1'b0);
    chk({paused, cts_pin, host_tx_valid}, 3'b010);
    want_send <= 1'b1;
    repeat (8) @(posedge clk);
    chk({push_to_talk_line, rx_enable}, 2'b10);
    want_send <= 1'b0;
    repeat (8) @(posedge clk);
    chk(rx_enable, 1'b1);
  endtask

  task automatic t_none();
    do_reset();
    bus(1'b1, 5'h00, 32'h1);
    send(257);
    bus(1'b0, 5'h18, 32'h0);
    chk({q[13], q[8:0], cts_pin}, 11'h601);
    bus(1'b1, 5'h18, 32'h2000);
    bus(1'b0, 5'h18, 32'h0);
    chk(q[13], 1'b0);
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) pl[i] = 8'h41 + 8'(i);
    do_reset();
    t_regs();
    t_sw();
    t_hw();
    t_manual();
    t_none();
    do_reset();
    {pl[0], pl[1], pl[2], pl[3]} = "TEST";
    bus(1'b1, 5'h00, 32'h11);
    frame(32, 4, 1'b0);
    report_and_stop();
  end
endmodule // rmlc_link_ctrl_test
